//--- sbtr_pkg.sv
// Package for synchronous bit timing recovery: constants and carrier types.
// Assumes a single 100 MHz core clock; no software-visible registers.
package sbtr_pkg;
  // Time base runs at 128 times the line rate
  localparam int unsigned TB_PER_BIT = 128;
  localparam int unsigned BIT_W = 7;
  localparam logic [6:0] BIT_WRAP = 7'h7F;
  localparam logic [6:0] BIT_MID = 7'h40;
  // Oscillator choices in Hz, lowest to highest
  localparam int unsigned OSC_HZ_0 = 76800;
  localparam int unsigned OSC_HZ_1 = 93230;
  localparam int unsigned OSC_HZ_2 = 125210;
  localparam int unsigned OSC_HZ_3 = 152016;
  localparam int unsigned CORE_HZ = 100_000_000;
  // Core cycles per oscillator period, rounded down
  localparam int unsigned OSC_DIV_0 = CORE_HZ / OSC_HZ_0;
  localparam int unsigned OSC_DIV_1 = CORE_HZ / OSC_HZ_1;
  localparam int unsigned OSC_DIV_2 = CORE_HZ / OSC_HZ_2;
  localparam int unsigned OSC_DIV_3 = CORE_HZ / OSC_HZ_3;
  localparam int unsigned OSC_CNT_W = 11;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    SBTR_RATE_0,
    SBTR_RATE_1,
    SBTR_RATE_2,
    SBTR_RATE_3
  } sbtr_rate_type;

  // Selection of regeneration type
  typedef struct packed {
    logic manual;
    logic manual_sync;
    sbtr_rate_type rate;
    logic [7:0] tb_div;
  } sbtr_ctrl_type;

  typedef struct packed {
    logic data;
    logic [6:0] phase;
  } sbtr_sample_type;
endpackage : sbtr_pkg

//--- sbtr_fifo.sv
// Generic valid/ready FIFO for regenerated samples.
// Assumes both sides on core_clk.
`timescale 1ns/100ps
`default_nettype none
module sbtr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = cnt_r != DEPTH[AW:0];
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : sbtr_fifo
`default_nettype wire

//--- sbtr_top.sv
// Synchronous bit timing recovery with add/subtract phase correction.
// Assumes line data already at logic levels, asynchronous to core_clk.
// Summary of operation
// - Time base divided to 128 times the line baud rate.
// - Oscillator picked from four fixed frequencies by rate alone.
// - Mark-to-space edge compared to bit timing; add or delete pulses.
// - Wrong phase moves one 1/128 bit step per mark-to-space edge.
// - In phase, add and subtract pulses alternate to hold phase.
// - Frequency error corrected one 1/128 bit step per accumulated pulse.
// - Every mark-to-space edge in sync mode deletes exactly one time-base pulse.
// - Early edge also inserts two pulses, one into second divider stage.
// - Late edge inserts nothing; net one pulse removed.
// - Line data feeds all logic except timing, which runs from oscillator, and mode selection, which takes ctrl and auto_sync.
// - Automatic mode unless manual; manual fixes start-stop or sync type.
// - Sample mid-bit on falling recovered timing; output half bit late.
`timescale 1ns/100ps
`default_nettype none
module sbtr_top #(
  parameter int unsigned FIFO_W = 8,
  parameter int unsigned FIFO_D = sbtr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Operator selections
  input wire sbtr_pkg::sbtr_ctrl_type ctrl,
  input wire logic auto_sync,
  // Line
  input wire logic line_data,
  // Regenerated stream
  output logic regen_data,
  output logic bit_clk,
  output logic sync_mode,
  output logic samp_valid,
  output logic [FIFO_W-1:0] samp_data,
  input wire logic samp_ready
);
  // ******************************************************
  // Input synchroniser
  // ******************************************************
  logic [2:0] line_sync_r;
  logic line_r;
  logic ms_edge;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      line_sync_r <= 3'h7;
    end else begin
      line_sync_r <= {line_sync_r[1:0], line_data};
    end
  end
  // Change counts once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      line_r <= 1'b1;
    end else if (line_sync_r[1] == line_sync_r[2]) begin
      line_r <= line_sync_r[2];
    end
  end
  assign ms_edge = line_r && (line_sync_r[1] == line_sync_r[2]) && !line_sync_r[2];

  // ******************************************************
  // Mode selection
  // ******************************************************
  logic sync_sel;
  always_comb begin
    sync_sel = ctrl.manual ? ctrl.manual_sync : auto_sync;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync_mode <= 1'b1;
    end else begin
      sync_mode <= sync_sel;
    end
  end

  // ******************************************************
  // Oscillator and time base; no line data enters here
  // ******************************************************
  logic [10:0] osc_div;
  logic [10:0] osc_cnt_r;
  logic osc_tick;
  always_comb begin
    unique case (ctrl.rate)
      sbtr_pkg::SBTR_RATE_0: osc_div = 11'(sbtr_pkg::OSC_DIV_0);
      sbtr_pkg::SBTR_RATE_1: osc_div = 11'(sbtr_pkg::OSC_DIV_1);
      sbtr_pkg::SBTR_RATE_2: osc_div = 11'(sbtr_pkg::OSC_DIV_2);
      sbtr_pkg::SBTR_RATE_3: osc_div = 11'(sbtr_pkg::OSC_DIV_3);
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b || osc_tick) begin
      osc_cnt_r <= 11'h001;
    end else begin
      osc_cnt_r <= osc_cnt_r + 11'h001;
    end
  end
  assign osc_tick = osc_cnt_r >= osc_div;

  // Divider of the oscillator down to 128x baud; tb_div is
  // oscillator periods per time-base pulse for the chosen rate.
  logic [7:0] tb_cnt_r;
  logic tb_tick;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tb_cnt_r <= 8'h01;
    end else if (osc_tick) begin
      tb_cnt_r <= (tb_cnt_r >= ctrl.tb_div) ? 8'h01 : tb_cnt_r + 8'h01;
    end
  end
  assign tb_tick = osc_tick && (tb_cnt_r >= ctrl.tb_div);

  // ******************************************************
  // Add/subtract logic
  // ******************************************************
  // Pending deletes and adds; an edge deletes one, an early edge adds
  // two, so the bit timer nets one step either way.
  logic [1:0] del_r;
  logic [1:0] add_r;
  logic stage2_r;
  logic [6:0] phase_r;
  logic early;
  assign early = phase_r >= sbtr_pkg::BIT_MID;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      del_r <= '0;
    end else if (ms_edge && sync_mode) begin
      del_r <= 2'h1;
    end else if (tb_tick && del_r != '0) begin
      del_r <= del_r - 2'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      add_r <= '0;
    end else if (ms_edge && sync_mode) begin
      add_r <= early ? 2'h2 : 2'h0;
    end else if (!tb_tick && add_r != '0) begin
      add_r <= add_r - 2'h1;
    end
  end
  // Second-stage insertion: one added pulse is worth one extra count
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stage2_r <= 1'b0;
    end else begin
      stage2_r <= !tb_tick && add_r == 2'h1;
    end
  end

  // ******************************************************
  // Bit timer
  // ******************************************************
  // Wrap stays near the edge: in phase, edges alternate early and late,
  // so adds and deletes alternate and hold phase.
  logic tb_step;
  logic [1:0] step_cnt;
  assign tb_step = (tb_tick && del_r == '0) || (!tb_tick && add_r == 2'h2);
  // A tick may meet a second-stage insertion; both must count
  assign step_cnt = {1'b0, tb_step} + {1'b0, stage2_r};
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      phase_r <= '0;
    end else if (step_cnt != 2'h0) begin
      phase_r <= phase_r + {5'h00, step_cnt};
    end
  end

  // ******************************************************
  // Regenerator
  // ******************************************************
  logic smp_ev;
  // Crossing into the second half, even by a double step
  assign smp_ev = phase_r < sbtr_pkg::BIT_MID &&
                  phase_r + {5'h00, step_cnt} >= sbtr_pkg::BIT_MID;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bit_clk <= 1'b0;
    end else begin
      bit_clk <= phase_r < sbtr_pkg::BIT_MID;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      regen_data <= 1'b1;
    end else if (smp_ev) begin
      regen_data <= line_r;
    end
  end

  sbtr_pkg::sbtr_sample_type smp;
  logic [FIFO_W-1:0] fifo_q;
  logic fifo_v;
  assign smp = '{data: line_r, phase: phase_r};
  sbtr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(smp_ev),
    .in_data(FIFO_W'(smp)),
    .in_ready(),
    .out_valid(fifo_v),
    .out_data(fifo_q),
    .out_ready(samp_ready && !samp_valid)
  );
  // Samples dropped while full: the line cannot be stalled
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      samp_valid <= 1'b0;
      samp_data <= '0;
    end else if (samp_valid && samp_ready) begin
      samp_valid <= 1'b0;
    end else if (!samp_valid && fifo_v && samp_ready) begin
      samp_valid <= 1'b1;
      samp_data <= fifo_q;
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  sequence s_edge;
    ms_edge && sync_mode;
  endsequence
  property p_del;
    @(posedge core_clk) disable iff (!rst_b) s_edge |=> del_r == 2'h1;
  endproperty
  a_del: assert property (p_del) else $error("edge did not queue delete");
  property p_early;
    @(posedge core_clk) disable iff (!rst_b) (s_edge and early) |=> add_r == 2'h2;
  endproperty
  a_early: assert property (p_early) else $error("early edge add missing");
  property p_late;
    @(posedge core_clk) disable iff (!rst_b) (s_edge and !early) |=> add_r == 2'h0;
  endproperty
  a_late: assert property (p_late) else $error("late edge added pulses");
  property p_mode;
    @(posedge core_clk) disable iff (!rst_b) ctrl.manual |=> sync_mode == $past(ctrl.manual_sync);
  endproperty
  a_mode: assert property (p_mode) else $error("manual mode ignored");
  property p_samp;
    @(posedge core_clk) disable iff (!rst_b) smp_ev |=> regen_data == $past(line_r);
  endproperty
  a_samp: assert property (p_samp) else $error("sample not taken");
  property p_step;
    @(posedge core_clk) disable iff (!rst_b) !(tb_step || stage2_r) |=> $stable(phase_r);
  endproperty
  a_step: assert property (p_step) else $error("timer moved without pulse");
  property p_osc;
    @(posedge core_clk) disable iff (!rst_b) osc_tick |=> osc_cnt_r == 11'h001;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator divider bad");
  property p_tb;
    @(posedge core_clk) disable iff (!rst_b)
      osc_tick && !tb_tick |=> tb_cnt_r == $past(tb_cnt_r) + 8'h01;
  endproperty
  a_tb: assert property (p_tb) else $error("time base off oscillator");
endmodule : sbtr_top
`default_nettype wire

//--- sbtr_line_model.sv
// Model of the serial telegraph line that feeds the repeater.
// Assumes levels already converted: mark is 1, and the line idles at mark.
`timescale 1ns/100ps
`default_nettype none
module sbtr_line_model (
  // Clock
  input wire logic core_clk,
  // Requests from the bench
  input wire logic req_valid,
  input wire logic req_level,
  output logic req_ready,
  // Line toward the repeater
  output logic line_data
);
  initial line_data = 1'b1;
  assign req_ready = 1'b1;
  // Level changes on a clock edge only; skew to the core clock is left to the repeater
  always @(posedge core_clk) begin
    if (req_valid) begin
      line_data <= req_level;
    end
  end
endmodule : sbtr_line_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the synchronous bit timing recovery block.
// Assumes the fastest oscillator and one oscillator tick per time-base pulse.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int TBP = sbtr_pkg::OSC_DIV_3;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  sbtr_pkg::sbtr_ctrl_type ctrl = '0;
  logic auto_sync = 1'b1;
  logic samp_ready = 1'b0;
  logic req_valid = 1'b0;
  logic req_level = 1'b1;
  logic line_data, regen_data, bit_clk, sync_mode, samp_valid, req_ready;
  logic [7:0] samp_data;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, seed, n;

  sbtr_top #(.FIFO_W(8), .FIFO_D(16)) sbtr_top_i (
    .core_clk(core_clk), .rst_b(rst_b), .ctrl(ctrl), .auto_sync(auto_sync),
    .line_data(line_data), .regen_data(regen_data), .bit_clk(bit_clk),
    .sync_mode(sync_mode), .samp_valid(samp_valid), .samp_data(samp_data),
    .samp_ready(samp_ready));
  sbtr_line_model sbtr_line_model_i (
    .core_clk(core_clk), .req_valid(req_valid), .req_level(req_level),
    .req_ready(req_ready), .line_data(line_data));

  always #5 core_clk = ~core_clk;

  // Random stalls on the sample stream; hang guard sized for one bit and a margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    samp_ready <= 1'($urandom % 2);
    if (cyc == 95000) begin
      fail_count++;
      test_done();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic set_line(input logic lvl);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_level <= lvl;
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : set_line

  task automatic wait_clk(input logic lvl, input int lim);
    int k;
    k = 0;
    while (bit_clk !== lvl && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    chk("bit_clk level", {31'h0, bit_clk}, {31'h0, lvl});
  endtask : wait_clk

  // Rounds a span of core cycles to whole time-base pulses
  function automatic int ticks(input int dt);
    return (dt + TBP / 2) / TBP;
  endfunction : ticks

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = $urandom(32'hd253);
    ctrl.rate = sbtr_pkg::SBTR_RATE_3;
    ctrl.tb_div = 8'h01;
    repeat (12) @(posedge core_clk);
    chk("regen_data in reset", {31'h0, regen_data}, 32'h1);
    chk("sync_mode in reset", {31'h0, sync_mode}, 32'h1);
    chk("samp_valid in reset", {31'h0, samp_valid}, 32'h0);
    rst_b <= 1'b1;
    // Every manual and automatic selection, the unused input random except manual_sync held 1 for automatic sync
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      ctrl.manual <= i[1];
      ctrl.manual_sync <= i[0] | (~i[1] & 1'($urandom % 2));
      auto_sync <= i[1] ? 1'($urandom % 2) : i[0];
      repeat (3) @(posedge core_clk);
      chk("sync_mode select", {31'h0, sync_mode}, {31'h0, i[0]});
    end
    // Late edge in the first half: one pulse deleted, mid-bit one pulse later
    wait_clk(1'b1, 2 * TBP);
    t0 = cyc;
    repeat (TBP + $urandom % (4 * TBP)) @(posedge core_clk);
    set_line(1'b0);
    wait_clk(1'b0, 70 * TBP);
    chk("late half bit", ticks(cyc - t0), 32'd65);
    t0 = cyc;
    n = 0;
    while (!(samp_valid === 1'b1 && samp_ready === 1'b1) && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    chk("mid-bit sample", 32'(samp_data), {24'h0, 1'b0, sbtr_pkg::BIT_MID - 7'h01});
    chk("regen_data after sample", {31'h0, regen_data}, 32'h0);
    // Early edge in the second half: net one pulse added, wrap one pulse sooner
    set_line(1'b1);
    repeat (2 * TBP + $urandom % (6 * TBP)) @(posedge core_clk);
    set_line(1'b0);
    wait_clk(1'b1, 70 * TBP);
    chk("early half bit", ticks(cyc - t0), 32'd63);
    test_done();
  end
endmodule : tb
`default_nettype wire
